// ### shared/pfc_defs.svh
/*
 * Timing counts, command bytes and field positions for the parallel flash host controller.
 * Assumes a 250 MHz system clock; counts are derived from the printed times.
 */
`ifndef PFC_DEFS_SVH
`define PFC_DEFS_SVH

`define PFC_CLK_MHZ          250
`define PFC_WP_NS            200
`define PFC_WPH_NS           200
`define PFC_AS_NS            10
`define PFC_ACC_NS           150
`define PFC_BLC_US           150
`define PFC_WC_MS            20
`define PFC_PWRUP_MS         20
// Least times round up to whole cycles.
`define PFC_WP_CYC           ((`PFC_WP_NS * `PFC_CLK_MHZ + 999) / 1000)
`define PFC_WPH_CYC          ((`PFC_WPH_NS * `PFC_CLK_MHZ + 999) / 1000)
`define PFC_AS_CYC           ((`PFC_AS_NS * `PFC_CLK_MHZ + 999) / 1000)
`define PFC_ACC_CYC          ((`PFC_ACC_NS * `PFC_CLK_MHZ + 999) / 1000)
// Longest gap between loads rounds down; the host keeps half of it as margin.
`define PFC_BLC_CYC          ((`PFC_BLC_US * `PFC_CLK_MHZ) / 2)
`define PFC_WC_CYC           (`PFC_WC_MS * 1000 * `PFC_CLK_MHZ)
`define PFC_PWRUP_CYC        (`PFC_PWRUP_MS * 1000 * `PFC_CLK_MHZ)

`define PFC_UNLOCK_A1        15'h5555
`define PFC_UNLOCK_A2        15'h2AAA
`define PFC_UNLOCK_D1        8'hAA
`define PFC_UNLOCK_D2        8'h55
`define PFC_CMD_PROGRAM      8'hA0
`define PFC_CMD_ID_ENTRY     8'h90
`define PFC_CMD_ID_EXIT      8'hF0
`define PFC_CMD_LOCK_PRE     8'h80
`define PFC_CMD_LOCK         8'h40
`define PFC_LOCK_DATA        8'hFF
`define PFC_LOCK_LO_ADDR     19'h00000
`define PFC_LOCK_HI_ADDR     19'h7FFFF
`define PFC_TOGGLE_BIT       6
`define PFC_POLL_BIT         7
`define PFC_SECTOR_LSB       8

`endif

// ### shared/pfc_pkg.sv
/*
 * Types shared by the parallel flash host controller.
 * Assumes nothing of its surroundings.
 */
package pfc_pkg;

	// Operations that the user side may request.
	typedef enum logic [2:0] {
		PFC_OP_READ,
		PFC_OP_PROGRAM,
		PFC_OP_ID_ENTRY,
		PFC_OP_ID_EXIT,
		PFC_OP_LOCK_LO,
		PFC_OP_LOCK_HI
	} pfc_op_t;

endpackage : pfc_pkg

// ### rtl/pfc_cycle.sv
/*
 * One strobe cycle on the flash pins: a byte load or a byte read.
 * Assumes the main controller holds address and data steady while busy.
 */
`timescale 1ns/10ps
`include "pfc_defs.svh"

module pfc_cycle
	import pfc_pkg::*;
(
	input  wire logic        sys_clk_in,    // System clock.
	input  wire logic        rst_n_in,      // Synchronous reset, active low.
	input  wire logic        start_in,      // One-cycle start pulse.
	input  wire logic        write_in,      // High for a byte load, low for a read.
	input  wire logic [7:0]  wdata_in,      // Byte to load.
	input  wire logic [7:0]  dq_in,         // Data lines from the flash.
	output logic             busy_out,      // Cycle in progress.
	output logic             done_out,      // One-cycle end pulse.
	output logic [7:0]       rdata_out,     // Byte read.
	output logic             ce_n_out,      // Chip enable, active low.
	output logic             oe_n_out,      // Output enable, active low.
	output logic             we_n_out,      // Write enable, active low.
	output logic [7:0]       dq_out,        // Data driven to the flash.
	output logic             dq_oe_out      // High while driving data lines.
);

	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] AS_C  = CNT_W'(`PFC_AS_CYC);
	localparam logic [CNT_W-1:0] WP_C  = CNT_W'(`PFC_WP_CYC);
	localparam logic [CNT_W-1:0] WPH_C = CNT_W'(`PFC_WPH_CYC);
	localparam logic [CNT_W-1:0] ACC_C = CNT_W'(`PFC_ACC_CYC);

	typedef enum {CY_IDLE, CY_SETUP, CY_PULSE, CY_HOLD} pfc_cy_st_t;

	typedef struct packed {
		pfc_cy_st_t       st;
		logic             wr;
		logic [CNT_W-1:0] cnt;
		logic             ce_n;
		logic             oe_n;
		logic             we_n;
		logic             dq_oe;
		logic [7:0]       dq;
		logic [7:0]       rdata;
		logic             done;
	} pfc_cy_t;

	pfc_cy_t s_ff;
	pfc_cy_t nxt_s;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Sequencer: setup with strobes idle, pulse low, then a high time before the next cycle.
	always_comb begin
		nxt_s      = s_ff;
		nxt_s.done = 1'b0;
		case (s_ff.st)
			CY_IDLE: begin
				if (start_in) begin
					nxt_s.st    = CY_SETUP;
					nxt_s.wr    = write_in;
					nxt_s.dq    = wdata_in;
					nxt_s.dq_oe = write_in;
					nxt_s.oe_n  = 1'b1;
					nxt_s.cnt   = AS_C;
				end
			end
			CY_SETUP: begin
				if (s_ff.cnt > 1) begin
					nxt_s.cnt = s_ff.cnt - 1'b1;
				end else begin
					nxt_s.st   = CY_PULSE;
					nxt_s.ce_n = 1'b0;
					nxt_s.we_n = !s_ff.wr;
					nxt_s.oe_n = s_ff.wr;
					nxt_s.cnt  = s_ff.wr ? WP_C : ACC_C;
				end
			end
			CY_PULSE: begin
				if (s_ff.cnt > 1) begin
					nxt_s.cnt = s_ff.cnt - 1'b1;
				end else begin
					nxt_s.st    = CY_HOLD;
					nxt_s.ce_n  = 1'b1;
					nxt_s.oe_n  = 1'b1;
					nxt_s.we_n  = 1'b1;
					nxt_s.cnt   = WPH_C;
					if (!s_ff.wr) begin
						nxt_s.rdata = dq_in;
					end
				end
			end
			CY_HOLD: begin
				nxt_s.dq_oe = 1'b0;
				if (s_ff.cnt > 1) begin
					nxt_s.cnt = s_ff.cnt - 1'b1;
				end else begin
					nxt_s.st   = CY_IDLE;
					nxt_s.done = 1'b1;
				end
			end
			default: nxt_s.st = CY_IDLE;
		endcase
	end

	// State register.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			s_ff <= '{st: CY_IDLE, wr: 1'b0, cnt: '0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
				dq_oe: 1'b0, dq: 8'h00, rdata: 8'h00, done: 1'b0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs straight from the state flip-flops; busy is decoded from the state.
	assign busy_out  = (s_ff.st != CY_IDLE);
	assign done_out  = s_ff.done;
	assign rdata_out = s_ff.rdata;
	assign ce_n_out  = s_ff.ce_n;
	assign oe_n_out  = s_ff.oe_n;
	assign we_n_out  = s_ff.we_n;
	assign dq_out    = s_ff.dq;
	assign dq_oe_out = s_ff.dq_oe;

	// Output enable stays high while write enable is low.
	property p_oe_high_in_load;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		!s_ff.we_n |-> s_ff.oe_n && s_ff.dq_oe && !s_ff.ce_n;
	endproperty
	a_oe_high_in_load: assert property (p_oe_high_in_load) else $error("oe low in load");

	// A write pulse lasts exactly its width count.
	property p_wp_width;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		$fell(s_ff.we_n) |-> !s_ff.we_n [*8] ##42 !s_ff.we_n ##1 s_ff.we_n;
	endproperty
	a_wp_width: assert property (p_wp_width) else $error("write pulse width wrong");

endmodule : pfc_cycle

// ### rtl/pfc_host.sv
/*
 * Host controller for an asynchronous parallel flash: reads, sector programming,
 * software identification entry and exit, and boot block lockout.
 * Assumes the flash pins are wired directly; the bench resolves the data bus from dq_oe_out.
 */
`timescale 1ns/10ps
`include "pfc_defs.svh"

module pfc_host
	import pfc_pkg::*;
#(
	parameter int  PWRUP_CYC = `PFC_PWRUP_CYC,  // Power-up wait in cycles.
	parameter int  WC_CYC    = `PFC_WC_CYC,     // Write cycle limit in cycles.
	parameter int  BLC_CYC   = `PFC_BLC_CYC,    // Longest gap between loads.
	parameter int  SECT_SZ   = 256              // Bytes per sector.
) (
	input  wire logic        sys_clk_in,    // System clock, 250 MHz.
	input  wire logic        rst_n_in,      // Synchronous reset, active low.
	input  wire logic        req_valid_in,  // Request offered.
	output logic             req_ready_out, // Request taken when valid.
	input  wire pfc_op_t     req_op_in,     // Operation.
	input  wire logic [18:0] req_addr_in,   // Byte address or sector base.
	input  wire logic [7:0]  wr_valid_in,   // Unused upper bits; bit 0 marks a byte offered.
	output logic             wr_ready_out,  // Program byte taken.
	input  wire logic [7:0]  wr_data_in,    // Program byte, in sector order.
	output logic             rsp_valid_out, // One-cycle end pulse.
	output logic [7:0]       rsp_data_out,  // Read data.
	output logic             rsp_timeout_out, // Write cycle overran its limit.
	output logic [18:0]      addr_out,      // Flash address lines.
	output logic             ce_n_out,      // Chip enable, active low.
	output logic             oe_n_out,      // Output enable, active low.
	output logic             we_n_out,      // Write enable, active low.
	input  wire logic [7:0]  dq_in,         // Data lines from flash.
	output logic [7:0]       dq_out,        // Data lines to flash.
	output logic             dq_oe_out      // High while host drives data.
);

	localparam int TW = 24;
	localparam logic [7:0] SECT_LAST = 8'(SECT_SZ - 1);

	typedef enum {ST_PWRUP, ST_IDLE, ST_CMD, ST_DATA, ST_READ, ST_POLL, ST_PAUSE} pfc_st_t;

	typedef struct packed {
		pfc_st_t     st;
		pfc_op_t     op;
		logic [2:0]  step;
		logic [7:0]  idx;
		logic [18:0] addr;
		logic [7:0]  wdata;
		logic        cy_wr;
		logic        cy_go;
		logic [TW-1:0] tmr;
		logic        have_prev;
		logic [7:0]  prev;
		logic        rsp;
		logic        tout;
		logic [7:0]  rdata;
	} pfc_s_t;

	pfc_s_t s_ff;
	pfc_s_t nxt_s;

	logic       cy_busy;
	logic       cy_done;
	logic [7:0] cy_rdata;
	logic [2:0] seq_len;
	logic [7:0] seq_d;
	logic [14:0] seq_a;

	////////////////////////////////////////////////////////////////////////////////////////////
	// Strobe cycle engine.
	pfc_cycle u_cycle (
		.sys_clk_in (sys_clk_in),
		.rst_n_in   (rst_n_in),
		.start_in   (s_ff.cy_go),
		.write_in   (s_ff.cy_wr),
		.wdata_in   (s_ff.wdata),
		.dq_in      (dq_in),
		.busy_out   (cy_busy),
		.done_out   (cy_done),
		.rdata_out  (cy_rdata),
		.ce_n_out   (ce_n_out),
		.oe_n_out   (oe_n_out),
		.we_n_out   (we_n_out),
		.dq_out     (dq_out),
		.dq_oe_out  (dq_oe_out)
	);

	////////////////////////////////////////////////////////////////////////////////////////////
	// Command table: unlock prefix, then the operation byte, then for lockout a second prefix.
	always_comb begin
		seq_a = `PFC_UNLOCK_A1;
		seq_d = `PFC_UNLOCK_D1;
		seq_len = 3'd3;
		if (s_ff.op == PFC_OP_LOCK_LO || s_ff.op == PFC_OP_LOCK_HI) begin
			seq_len = 3'd6;
		end
		case (s_ff.step)
			3'd0, 3'd3: begin
				seq_a = `PFC_UNLOCK_A1;
				seq_d = `PFC_UNLOCK_D1;
			end
			3'd1, 3'd4: begin
				seq_a = `PFC_UNLOCK_A2;
				seq_d = `PFC_UNLOCK_D2;
			end
			3'd2: begin
				seq_a = `PFC_UNLOCK_A1;
				case (s_ff.op)
					PFC_OP_PROGRAM:  seq_d = `PFC_CMD_PROGRAM;
					PFC_OP_ID_ENTRY: seq_d = `PFC_CMD_ID_ENTRY;
					PFC_OP_ID_EXIT:  seq_d = `PFC_CMD_ID_EXIT;
					default:         seq_d = `PFC_CMD_LOCK_PRE;
				endcase
			end
			default: begin
				seq_a = `PFC_UNLOCK_A1;
				seq_d = `PFC_CMD_LOCK;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// Main sequencer.
	always_comb begin
		nxt_s       = s_ff;
		nxt_s.cy_go = 1'b0;
		nxt_s.rsp   = 1'b0;
		case (s_ff.st)
			ST_PWRUP: begin
				if (s_ff.tmr >= TW'(PWRUP_CYC - 1)) begin
					nxt_s.st = ST_IDLE;
				end else begin
					nxt_s.tmr = s_ff.tmr + 1'b1;
				end
			end
			ST_IDLE: begin
				if (req_valid_in) begin
					nxt_s.op   = req_op_in;
					nxt_s.step = 3'd0;
					nxt_s.idx  = 8'h00;
					nxt_s.tout = 1'b0;
					nxt_s.have_prev = 1'b0;
					if (req_op_in == PFC_OP_READ) begin
						nxt_s.st    = ST_READ;
						nxt_s.addr  = req_addr_in;
						nxt_s.cy_wr = 1'b0;
						nxt_s.cy_go = 1'b1;
					end else begin
						nxt_s.st = ST_CMD;
						nxt_s.addr = (req_op_in == PFC_OP_LOCK_HI) ? `PFC_LOCK_HI_ADDR :
							(req_op_in == PFC_OP_LOCK_LO) ? `PFC_LOCK_LO_ADDR : req_addr_in;
					end
				end
			end
			ST_CMD: begin
				if (!cy_busy && !s_ff.cy_go) begin
					if (s_ff.step == seq_len) begin
						nxt_s.st = (s_ff.op == PFC_OP_PROGRAM || s_ff.op == PFC_OP_LOCK_LO ||
							s_ff.op == PFC_OP_LOCK_HI) ? ST_DATA : ST_PAUSE;
						nxt_s.tmr = '0;
					end else begin
						nxt_s.wdata = seq_d;
						nxt_s.cy_wr = 1'b1;
						nxt_s.cy_go = 1'b1;
						nxt_s.step  = s_ff.step + 1'b1;
					end
				end
			end
			ST_DATA: begin
				nxt_s.tmr = s_ff.tmr + 1'b1;
				// Lockout sends its fixed byte at once; program bytes wait for the source.
				if (!cy_busy && !s_ff.cy_go && (wr_valid_in[0] || s_ff.op != PFC_OP_PROGRAM)) begin
					nxt_s.wdata = (s_ff.op == PFC_OP_PROGRAM) ? wr_data_in : `PFC_LOCK_DATA;
					nxt_s.cy_wr = 1'b1;
					nxt_s.cy_go = 1'b1;
					nxt_s.tmr   = '0;
					// The offset is latched with the byte, so the load lands where it belongs.
					if (s_ff.op == PFC_OP_PROGRAM) begin
						nxt_s.addr = {s_ff.addr[18:`PFC_SECTOR_LSB], s_ff.idx};
					end
					if (s_ff.op != PFC_OP_PROGRAM || s_ff.idx == SECT_LAST) begin
						nxt_s.st = (s_ff.op == PFC_OP_PROGRAM) ? ST_POLL : ST_PAUSE;
					end
					nxt_s.idx = s_ff.idx + 1'b1;
				end
			end
			ST_POLL: begin
				nxt_s.tmr = s_ff.tmr + 1'b1;
				if (s_ff.tmr >= TW'(WC_CYC - 1)) begin
					nxt_s.st = ST_IDLE;
					nxt_s.tout = 1'b1;
					nxt_s.rsp = 1'b1;
				end else if (!cy_busy && !s_ff.cy_go) begin
					// The end of the last byte load is not a polling read.
					if (cy_done && !s_ff.cy_wr) begin
						nxt_s.prev = cy_rdata;
						nxt_s.have_prev = 1'b1;
						if (s_ff.have_prev && cy_rdata[`PFC_TOGGLE_BIT] ==
							s_ff.prev[`PFC_TOGGLE_BIT]) begin
							nxt_s.st = ST_IDLE;
							nxt_s.rsp = 1'b1;
						end
					end else begin
						nxt_s.cy_wr = 1'b0;
						nxt_s.cy_go = 1'b1;
					end
				end
			end
			ST_PAUSE: begin
				nxt_s.tmr = s_ff.tmr + 1'b1;
				if (s_ff.tmr >= TW'(WC_CYC - 1)) begin
					nxt_s.st  = ST_IDLE;
					nxt_s.rsp = 1'b1;
				end
			end
			ST_READ: begin
				if (cy_done) begin
					nxt_s.rdata = cy_rdata;
					nxt_s.rsp   = 1'b1;
					nxt_s.st    = ST_IDLE;
				end
			end
			default: nxt_s.st = ST_IDLE;
		endcase
	end

	// State register.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			s_ff <= '{st: ST_PWRUP, op: PFC_OP_READ, step: 3'd0, idx: 8'h00, addr: 19'h00000,
				wdata: 8'h00, cy_wr: 1'b0, cy_go: 1'b0, tmr: '0, have_prev: 1'b0,
				prev: 8'h00, rsp: 1'b0, tout: 1'b0, rdata: 8'h00};
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Address mux: command cycles use the unlock address; address bits 18:15 stay on the upper lines.
	always_comb begin
		addr_out = s_ff.addr;
		if (s_ff.st == ST_CMD) begin
			addr_out = {s_ff.addr[18:15], seq_a};
			if (s_ff.step != 3'd0) begin
				addr_out = {s_ff.addr[18:15], s_ff.step == 3'd2 || s_ff.step == 3'd5 ?
					`PFC_UNLOCK_A2 : `PFC_UNLOCK_A1};
			end
		end else if (s_ff.st == ST_DATA) begin
			addr_out = s_ff.addr;
		end
	end

	// Handshakes and answers.
	assign req_ready_out   = (s_ff.st == ST_IDLE);
	assign wr_ready_out    = (s_ff.st == ST_DATA) && !cy_busy && !s_ff.cy_go &&
		(s_ff.op == PFC_OP_PROGRAM);
	assign rsp_valid_out   = s_ff.rsp;
	assign rsp_data_out    = s_ff.rdata;
	assign rsp_timeout_out = s_ff.tout;

	// The sector address never changes within a program load.
	property p_sector_stable;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(s_ff.st == ST_DATA) && $fell(we_n_out) && $past(s_ff.st) == ST_DATA |->
		addr_out[18:8] == $past(addr_out[18:8]);
	endproperty
	a_sector_stable: assert property (p_sector_stable) else $error("sector moved");

	// No strobe before the power-up wait ends.
	property p_pwrup_quiet;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		s_ff.st == ST_PWRUP |-> ce_n_out && we_n_out;
	endproperty
	a_pwrup_quiet: assert property (p_pwrup_quiet) else $error("strobe in power-up");

	// A load opens well inside the window after a byte is offered.
	property p_load_gap;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		wr_valid_in[0] && wr_ready_out |-> ##[1:10] !we_n_out;
	endproperty
	a_load_gap: assert property (p_load_gap) else $error("load late");

	// Address is constant while polling reads are strobed.
	property p_poll_addr;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		s_ff.st == ST_POLL && $past(s_ff.st) == ST_POLL |-> $stable(addr_out);
	endproperty
	a_poll_addr: assert property (p_poll_addr) else $error("poll address moved");

	// The gap since the last load stays inside the host's share of the byte-load window.
	property p_load_window;
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		s_ff.st == ST_DATA |-> s_ff.tmr < TW'(BLC_CYC);
	endproperty
	a_load_window: assert property (p_load_window) else $error("load window overrun");

endmodule : pfc_host

// ### verification/pfc_flash_model.sv
/*
 * Behavioural flash device seen by the host controller: strobe decode, command
 * sequences, sector loads, write cycle with polling, identification and lockout.
 * Assumes the bench feeds the host's pins here and returns dq_out to the host.
 */
`timescale 1ns/10ps

module pfc_flash_model #(
	parameter logic [7:0] MFR_CODE = 8'h5A,     // Arbitrary value.
	parameter logic [7:0] DEV_CODE = 8'h3C,     // Arbitrary value.
	parameter real        BLC_NS   = 1000.0,    // Byte-load window.
	parameter real        WC_NS    = 2000.0,    // Prompt write cycle.
	parameter real        SLOW_NS  = 20000.0    // Slow write cycle.
) (
	input  wire logic [18:0] addr_in,     // Address lines.
	input  wire logic        ce_n_in,     // Chip enable.
	input  wire logic        oe_n_in,     // Output enable.
	input  wire logic        we_n_in,     // Write enable.
	input  wire logic [7:0]  host_dq_in,  // Data driven by the host.
	input  wire logic        host_oe_in,  // Host drives data.
	input  wire logic        slow_in,     // Select the slow write cycle.
	input  wire logic        id_hv_in,    // High identification voltage on address nine.
	output logic      [7:0]  dq_out,      // Resolved data bus.
	output logic             busy_out     // Write cycle running.
);
	logic [7:0]  mem [logic [18:0]];
	logic [7:0]  last_d;
	logic [18:0] lat_a;
	logic        id_mode, prog_mode, lock_wait, lock_lo, lock_hi, tog;
	int          seq;
	real         last_rise, wc_end;
	wire         load = !ce_n_in && !we_n_in && oe_n_in;
	wire         rd_mode = !ce_n_in && !oe_n_in && we_n_in;

	// Power-up state: normal reads, nothing locked.
	initial begin
		{id_mode, prog_mode, lock_wait, lock_lo, lock_hi, tog, busy_out} = 7'h00;
		{seq, last_d, dq_out} = 48'h0;
		last_rise = 0.0;
		wc_end = 0.0;
	end

	// Read value: polling while busy, then identification, then the array.
	function automatic logic [7:0] rd(input logic [18:0] a);
		if (busy_out) return {~last_d[7], tog, last_d[5:0]};
		if (id_hv_in && a[18:1] == 18'h00100) return a[0] ? DEV_CODE : MFR_CODE;
		if (id_mode && a == 19'h00000) return MFR_CODE;
		if (id_mode && a == 19'h00001) return DEV_CODE;
		if (id_mode && a == 19'h00002) return lock_lo ? 8'hFF : 8'hFE;
		if (id_mode && a == 19'h7FFF2) return lock_hi ? 8'hFF : 8'hFE;
		return mem.exists(a) ? mem[a] : 8'hFF;
	endfunction : rd

	// One byte load: sector data, lock target or a step of a command sequence.
	task automatic take(input logic [18:0] a, input logic [7:0] d);
		last_rise = $realtime;
		if (prog_mode) begin
			mem[a] = d;
			last_d = d;
			busy_out = 1'b1;
		end else if (lock_wait) begin
			lock_wait = 1'b0;
			if (d == 8'hFF && a[18:14] == 5'h00) lock_lo = 1'b1;
			if (d == 8'hFF && a[18:14] == 5'h1F) lock_hi = 1'b1;
		end else if ((seq == 0 || seq == 3) && d == 8'hAA && a[14:0] == 15'h5555) begin
			seq++;
		end else if ((seq == 1 || seq == 4) && d == 8'h55 && a[14:0] == 15'h2AAA) begin
			seq++;
		end else if (seq == 2 && a[14:0] == 15'h5555) begin
			seq = (d == 8'h80) ? 3 : 0;
			if (d == 8'hA0) prog_mode = 1'b1;
			if (d == 8'h90) id_mode = 1'b1;
			if (d == 8'hF0) id_mode = 1'b0;
		end else begin
			lock_wait = (seq == 5 && d == 8'h40 && a[14:0] == 15'h5555);
			seq = 0;
		end
	endtask : take

	// Address latches on the falling strobe, data on the rising one.
	always @(posedge load) begin
		lat_a = addr_in;
	end
	always @(negedge load) begin
		if (oe_n_in) take(lat_a, host_dq_in);
	end

	// Each read strobe flips the toggle bit while busy.
	always @(posedge rd_mode) begin
		if (busy_out) tog = ~tog;
	end

	// Load window closes, then the write cycle runs out.
	always begin
		#50;
		if (prog_mode && busy_out && $realtime - last_rise > BLC_NS) begin
			prog_mode = 1'b0;
			wc_end = $realtime + (slow_in ? SLOW_NS : WC_NS);
		end else if (!prog_mode && busy_out && $realtime >= wc_end) begin
			busy_out = 1'b0;
		end
	end

	// Bus: host data, read data, else a changing pattern once released.
	always @(addr_in, rd_mode, host_dq_in, host_oe_in, busy_out, tog, id_mode) begin
		if (host_oe_in) dq_out = host_dq_in;
		else if (rd_mode) dq_out = rd(addr_in);
		else dq_out = ~dq_out;
	end
endmodule : pfc_flash_model

// ### verification/pfc_host_tb.sv
/*
 * Self-checking bench for the flash host controller against the flash model.
 * Assumes the package and the defines header are compiled first.
 */
`timescale 1ns/10ps

module pfc_host_tb;
	import pfc_pkg::*;
	localparam int         WAIT_CYC = 2000;
	localparam logic [7:0] MFR = 8'h5A; // Arbitrary value.
	localparam logic [7:0] DEV = 8'h3C; // Arbitrary value.
	typedef struct {pfc_op_t op; logic [18:0] a; logic [7:0] e; logic c;} pfc_row_t;

	logic        clk, rst_n, req_valid, req_ready, wr_ready, rsp_valid, rsp_timeout;
	logic        ce_n, oe_n, we_n, dq_oe, slow, busy, hv;
	pfc_op_t     req_op;
	logic [18:0] req_addr, addr;
	logic [7:0]  wr_valid, wr_data, rsp_data, dq_in, dq_out, rd;
	int          error_cnt, total_checks, n;
	pfc_row_t    rows [11];

	pfc_host #(.PWRUP_CYC(WAIT_CYC), .WC_CYC(WAIT_CYC)) DUT (
		.sys_clk_in(clk), .rst_n_in(rst_n), .req_valid_in(req_valid),
		.req_ready_out(req_ready), .req_op_in(req_op), .req_addr_in(req_addr),
		.wr_valid_in(wr_valid), .wr_ready_out(wr_ready), .wr_data_in(wr_data),
		.rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data), .rsp_timeout_out(rsp_timeout),
		.addr_out(addr), .ce_n_out(ce_n), .oe_n_out(oe_n), .we_n_out(we_n),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe_out(dq_oe));
	pfc_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) flash (
		.addr_in(addr), .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n),
		.host_dq_in(dq_out), .host_oe_in(dq_oe), .slow_in(slow), .id_hv_in(hv),
		.dq_out(dq_in), .busy_out(busy));

	// Clock at 250 MHz.
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Verdict and end of run.
	task automatic stop_test();
		if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : stop_test

	// Compare one value and report a mismatch.
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// One falling edge of a bounded wait; an exhausted bound ends the run.
	task automatic tick(inout int k, input int lim);
		@(negedge clk);
		k++;
		if (k > lim) begin
			error_cnt++;
			$display("ERROR t=%0t wait=%h limit=%h", $time, k, lim);
			stop_test();
		end
	endtask : tick

	// Issue one operation, feed a whole sector for a program, await the answer.
	task automatic run_op(input pfc_op_t op, input logic [18:0] a, output logic [7:0] d);
		int k;
		@(negedge clk);
		req_valid = 1'b1;
		req_op = op;
		req_addr = a;
		k = 0;
		while (req_ready !== 1'b1) tick(k, 40000);
		@(negedge clk);
		req_valid = 1'b0;
		for (int i = 0; op == PFC_OP_PROGRAM && i < 256; i++) begin
			{wr_valid, wr_data, k} = {8'h01, 8'(i) ^ 8'h5A, 32'h0};
			while (wr_ready !== 1'b1) tick(k, 500);
			@(negedge clk);
		end
		wr_valid = 8'h00;
		k = 0;
		while (rsp_valid !== 1'b1) tick(k, 40000);
		d = rsp_data;
	endtask : run_op

	// Release reset and check the power-up wait with strobes idle.
	task automatic power_up();
		int k;
		k = 0;
		rst_n = 1'b1;
		while (req_ready !== 1'b1) tick(k, 3000);
		check({7'h0, k >= WAIT_CYC}, 8'h01);
		check({5'h0, ce_n, we_n, dq_oe}, 8'h06);
	endtask : power_up

	// Strobe combinations on every cycle: no load with output enable low, no contention.
	always @(negedge clk) begin
		if (rst_n && !ce_n && !we_n && !oe_n) check(8'h01, 8'h00);
		if (rst_n && dq_oe && !ce_n && !oe_n) check(8'h02, 8'h00);
	end

	// Main sequence: reset, sector program, table of reads, lockout, reset, overrun.
	initial begin
		{rst_n, req_valid, req_addr, wr_valid, wr_data, slow, hv} = '0;
		req_op = PFC_OP_READ;
		error_cnt = 0;
		total_checks = 0;
		rows = '{'{PFC_OP_READ, 19'h12300, 8'h5A, 1'b1}, '{PFC_OP_READ, 19'h123FF, 8'hA5, 1'b1},
			'{PFC_OP_READ, 19'h12380, 8'hDA, 1'b1}, '{PFC_OP_ID_ENTRY, 19'h0, 8'h0, 1'b0},
			'{PFC_OP_READ, 19'h00000, MFR, 1'b1}, '{PFC_OP_READ, 19'h00001, DEV, 1'b1},
			'{PFC_OP_READ, 19'h00002, 8'hFE, 1'b1}, '{PFC_OP_READ, 19'h7FFF2, 8'hFE, 1'b1},
			'{PFC_OP_ID_EXIT, 19'h0, 8'h0, 1'b0}, '{PFC_OP_READ, 19'h12301, 8'h5B, 1'b1},
			'{PFC_OP_READ, 19'h00000, 8'hFF, 1'b1}};
		repeat (16) @(negedge clk);
		check({3'h0, ce_n, oe_n, we_n, dq_oe, req_ready}, 8'h1C);
		power_up();
		run_op(PFC_OP_PROGRAM, 19'h12300, rd);
		check({6'h0, busy, rsp_timeout}, 8'h00);
		foreach (rows[i]) begin
			run_op(rows[i].op, rows[i].a, rd);
			if (rows[i].c) check(rd, rows[i].e);
		end
		run_op(PFC_OP_LOCK_LO, 19'h0, rd);
		run_op(PFC_OP_ID_ENTRY, 19'h0, rd);
		run_op(PFC_OP_READ, 19'h00002, rd);
		check(rd, 8'hFF);
		run_op(PFC_OP_READ, 19'h7FFF2, rd);
		check(rd, 8'hFE);
		run_op(PFC_OP_LOCK_HI, 19'h0, rd);
		run_op(PFC_OP_READ, 19'h7FFF2, rd);
		check(rd, 8'hFF);
		run_op(PFC_OP_ID_EXIT, 19'h0, rd);
		// High identification voltage: codes appear at offsets zero and one.
		hv = 1'b1;
		run_op(PFC_OP_READ, 19'h00200, rd);
		check(rd, MFR);
		run_op(PFC_OP_READ, 19'h00201, rd);
		check(rd, DEV);
		hv = 1'b0;
		// Reset in the middle of a read: strobes return high, no answer.
		@(negedge clk);
		req_valid = 1'b1;
		req_op = PFC_OP_READ;
		req_addr = 19'h12300;
		@(negedge clk);
		req_valid = 1'b0;
		repeat (20) @(negedge clk);
		rst_n = 1'b0;
		repeat (16) @(negedge clk);
		check({3'h0, ce_n, oe_n, we_n, dq_oe, rsp_valid}, 8'h1C);
		power_up();
		// Write cycle longer than the host allows must be flagged.
		slow = 1'b1;
		run_op(PFC_OP_PROGRAM, 19'h45600, rd);
		check({7'h0, rsp_timeout}, 8'h01);
		stop_test();
	end
endmodule : pfc_host_tb
